/* core/pmc_config_regs.sv */
/*
  Configuration header tail and power management capability.
  Assumes a decoded configuration port on the PCI clock.
*/
// Operation
// - Capability pointer is fixed read-only DCh.
// - Interrupt pin reads as INTA, read-only.
// - Minimum grant reads 08h, read-only.
// - Maximum latency reads 18h, read-only.
// - Capability_identifier reads 01h, power management.
// - Next capability link reads zero, end of list.
// - Capabilities word depends on auxiliary supply presence.
// - Wake states: all with aux supply, else D0 to D3hot.
// - D1 and D2 support bits read one.
// - Auxiliary current field reads zero.
// - Special initialization bit reads one.
// - Wake clock bit and bit above it read zero.
// - Version field reads 010b.
// - Wake event sets status regardless of enable.
// - Writing one clears status, releases wake pin, clears mirror.
// - With enable set, wake pin follows status.
// - Wake pin asserts only while enable is one.
// - Scale nonzero for selections 0-8, zero for 9-15.
// - Data select chooses data register and scale entry.
// - Dynamic data bit and reserved fields read zero.
// - Power state field is read/write, 00 D0 to 11 D3.
// - Data register is hard-coded by data select.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"

module ppm_config_regs
  import ppm_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire ppm_cfg_req_t cfg_req,
  output logic       [31:0] cfg_rdata,
  output logic              cfg_ack,
  input  wire logic         aux_supply,
  input  wire logic         wake_event,
  input  wire logic         drv_pme_clr,
  output logic              drv_pme_status,
  output ppm_pwr_state_t    pwr_state,
  output logic              pme_n_o,
  output logic              pme_n_oe
);

  // ========================================================
  // Storage
  logic [7:0]     irq_line_q;
  logic [7:0]     irq_line_d;
  ppm_pwr_state_t pstate_q;
  ppm_pwr_state_t pstate_d;
  logic [3:0]     sel_q;
  logic [3:0]     sel_d;
  logic           pme_en_q;
  logic           pme_en_d;
  logic           pme_stat;
  logic [31:0]    rdata_q;
  logic [31:0]    rdata_d;
  logic           ack_q;

  // ========================================================
  // Address decode
  wire hit_irq;
  wire hit_cs;
  wire wr_irq;
  wire wr_cs_lo;
  wire wr_cs_hi;
  wire pme_clr;

  assign hit_irq  = cfg_req.idx == `PPM_IDX_IRQ;
  assign hit_cs   = cfg_req.idx == `PPM_IDX_PWRCS;
  assign wr_irq   = cfg_req.wr & hit_irq & cfg_req.be[0];
  assign wr_cs_lo = cfg_req.wr & hit_cs & cfg_req.be[0];
  assign wr_cs_hi = cfg_req.wr & hit_cs & cfg_req.be[1];
  assign pme_clr  = wr_cs_hi & cfg_req.wdata[`PPM_CS_STAT_BIT];

  // ========================================================
  // Writable fields; other bits have no storage here, wake status is held in u_stat
  assign irq_line_d = wr_irq ? cfg_req.wdata[7:0] : irq_line_q;
  assign pstate_d = wr_cs_lo ? ppm_pwr_state_t'(cfg_req.wdata[1:0])
                             : pstate_q;
  assign sel_d = wr_cs_hi ? cfg_req.wdata[12:9] : sel_q;
  assign pme_en_d = wr_cs_hi ? cfg_req.wdata[`PPM_CS_EN_BIT]
                             : pme_en_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_line_q <= 8'h00;
      pstate_q   <= PPM_D0;
      sel_q      <= 4'h0;
      pme_en_q   <= 1'b0;
    end
    else
    begin
      irq_line_q <= irq_line_d;
      pstate_q   <= pstate_d;
      sel_q      <= sel_d;
      pme_en_q   <= pme_en_d;
    end
  end

  assign pwr_state = pstate_q;

  // ========================================================
  // Wake status and its driver-visible mirror
  ppm_wake_flag u_stat (
    .clk    (clk),
    .rst    (rst),
    .set    (wake_event),
    .clr    (pme_clr),
    .flag_q (pme_stat)
  );

  ppm_wake_flag u_mirror (
    .clk    (clk),
    .rst    (rst),
    .set    (wake_event),
    .clr    (pme_clr | drv_pme_clr),
    .flag_q (drv_pme_status)
  );

  // Open-drain: only ever pulls low
  assign pme_n_o  = 1'b0;
  assign pme_n_oe = pme_en_q & pme_stat;

  // ========================================================
  // Data register
  logic [7:0] data_val;
  logic [1:0] data_scale;

  ppm_data_rom u_rom (
    .sel   (sel_q),
    .data  (data_val),
    .scale (data_scale)
  );

  // ========================================================
  // Read-back words
  wire [15:0] cap_word;
  wire [15:0] cs_word;
  wire [4:0]  pme_sup;

  assign pme_sup = aux_supply ? `PPM_PME_SUP_AUX
                              : `PPM_PME_SUP_PCI;
  // D2, D1, aux current, init, reserved, clock, version
  assign cap_word = {pme_sup, 1'b1, 1'b1, 3'b000, 1'b1,
                     1'b0, 1'b0, `PPM_VERSION};
  // Reserved and dynamic data read zero
  assign cs_word = {pme_stat, data_scale, sel_q, pme_en_q,
                    3'b000, 1'b0, 2'b00, pstate_q};

  always_comb
  begin
    case (cfg_req.idx)
      `PPM_IDX_CAPPTR: rdata_d = {24'h000000, `PPM_CAPPTR_VAL};
      `PPM_IDX_IRQ:    rdata_d = {`PPM_MAX_LAT_VAL, `PPM_MIN_GNT_VAL,
                                  `PPM_IRQ_PIN_VAL, irq_line_q};
      `PPM_IDX_CAPHDR: rdata_d = {cap_word, `PPM_NEXT_VAL,
                                  `PPM_CAP_ID_VAL};
      `PPM_IDX_PWRCS:  rdata_d = {data_val, 8'h00, cs_word};
      default:         rdata_d = 32'h00000000;
    endcase
  end

  // ========================================================
  // Answer one cycle after the request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 32'h00000000;
      ack_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= cfg_req.rd ? rdata_d : rdata_q;
      ack_q   <= cfg_req.rd | cfg_req.wr;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_ack   = ack_q;

  // ========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_capptr;
    cfg_req.rd && cfg_req.idx == `PPM_IDX_CAPPTR
      |=> cfg_ack && cfg_rdata == 32'h000000DC;
  endproperty
  a_capptr: assert property (p_capptr)
    else $error("capability pointer wrong");

  property p_irq_word;
    cfg_req.rd && hit_irq
      |=> cfg_rdata[31:8] == 24'h180801;
  endproperty
  a_irq_word: assert property (p_irq_word)
    else $error("fixed interrupt bytes wrong");

  property p_irq_line;
    wr_irq && !cfg_req.rd ##1 cfg_req.rd && hit_irq
      |=> cfg_rdata[7:0] == $past(cfg_req.wdata[7:0], 2);
  endproperty
  a_irq_line: assert property (p_irq_line)
    else $error("interrupt line not stored");

  property p_caphdr;
    cfg_req.rd && cfg_req.idx == `PPM_IDX_CAPHDR
      |=> cfg_rdata[15:0] == 16'h0001
          && cfg_rdata[26:16] == 11'h622
          && cfg_rdata[31:27] == ($past(aux_supply) ? 5'h1F : 5'h0F);
  endproperty
  a_caphdr: assert property (p_caphdr)
    else $error("capability header wrong");

  property p_wake_set;
    wake_event |=> pme_stat && drv_pme_status;
  endproperty
  a_wake_set: assert property (p_wake_set)
    else $error("wake event not recorded");

  property p_wake_clr;
    pme_clr && !wake_event |=> !pme_stat && !pme_n_oe && !drv_pme_status;
  endproperty
  a_wake_clr: assert property (p_wake_clr)
    else $error("write one did not clear status");

  property p_pin;
    pme_n_oe == (pme_en_q && pme_stat) && !pme_n_o;
  endproperty
  a_pin: assert property (p_pin)
    else $error("wake pin does not follow status");

  property p_pin_gate;
    !pme_en_q |-> !pme_n_oe;
  endproperty
  a_pin_gate: assert property (p_pin_gate)
    else $error("wake pin asserted while disabled");

  property p_scale;
    cfg_req.rd && hit_cs
      |=> (cfg_rdata[12:9] > 4'h8) == (cfg_rdata[14:13] == 2'h0);
  endproperty
  a_scale: assert property (p_scale)
    else $error("data scale wrong");

  property p_reserved;
    cfg_req.rd && hit_cs |=> cfg_rdata[7:2] == 6'h00
                             && cfg_rdata[23:16] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

  property p_pstate;
    wr_cs_lo |=> pwr_state == $past(cfg_req.wdata[1:0]);
  endproperty
  a_pstate: assert property (p_pstate)
    else $error("power state not written");

  property p_ro_hold;
    cfg_req.wr && !hit_irq && !hit_cs |=> $stable(irq_line_q)
                                          && $stable(sel_q);
  endproperty
  a_ro_hold: assert property (p_ro_hold)
    else $error("write to read-only space changed state");

  // Every access is answered, even one that is ignored
  property p_ack_pulse;
    cfg_req.rd || cfg_req.wr |=> cfg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("access not acknowledged");

  property p_ack_idle;
    !cfg_req.rd && !cfg_req.wr |=> !cfg_ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("acknowledge without access");

  property p_rdata_hold;
    !cfg_req.rd |=> $stable(cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");

  property p_irq_store;
    wr_irq |=> irq_line_q == $past(cfg_req.wdata[7:0]);
  endproperty
  a_irq_store: assert property (p_irq_store)
    else $error("interrupt line write lost");

  property p_sel_write;
    wr_cs_hi |=> sel_q == $past(cfg_req.wdata[12:9]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("data select write lost");

  property p_en_write;
    wr_cs_hi |=> pme_en_q == $past(cfg_req.wdata[8]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("wake enable write lost");

  // Expected table written out from the select read back
  property p_data_val;
    cfg_req.rd && hit_cs |=> cfg_rdata[31:24] ==
      ((cfg_rdata[12:9] == 4'h0 || cfg_rdata[12:9] == 4'h4) ? 8'h3C
       : (cfg_rdata[12:9] < 4'h8) ? 8'h2A : 8'h00);
  endproperty
  a_data_val: assert property (p_data_val)
    else $error("data register value wrong");

  property p_drv_clr;
    drv_pme_clr && !wake_event |=> !drv_pme_status;
  endproperty
  a_drv_clr: assert property (p_drv_clr)
    else $error("mirror not cleared by driver");

  property p_pstate_hold;
    !wr_cs_lo |=> $stable(pstate_q);
  endproperty
  a_pstate_hold: assert property (p_pstate_hold)
    else $error("power state changed without write");

  property p_unmapped;
    cfg_req.rd && !hit_irq && !hit_cs && cfg_req.idx != `PPM_IDX_CAPPTR
      && cfg_req.idx != `PPM_IDX_CAPHDR |=> cfg_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

endmodule
`default_nettype wire

/* core/pmc_consts.svh */
/*
  Constants for the power management configuration registers.
  Assumes inclusion by bare name from files under core/.
*/
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// ==========================================================
// Dword indices of configuration space
`define PPM_IDX_CAPPTR   6'h0D
`define PPM_IDX_IRQ      6'h0F
`define PPM_IDX_CAPHDR   6'h37
`define PPM_IDX_PWRCS    6'h38

// ==========================================================
// Fixed byte values
`define PPM_CAPPTR_VAL   8'hDC
`define PPM_IRQ_PIN_VAL  8'h01
`define PPM_MIN_GNT_VAL  8'h08
`define PPM_MAX_LAT_VAL  8'h18
`define PPM_CAP_ID_VAL   8'h01
`define PPM_NEXT_VAL     8'h00

// ==========================================================
// Capabilities word fields
`define PPM_PME_SUP_AUX  5'h1F
`define PPM_PME_SUP_PCI  5'h0F
`define PPM_VERSION      3'h2

// ==========================================================
// Control/status word bit positions, data scale value and last scaled select
`define PPM_CS_STAT_BIT  15
`define PPM_CS_EN_BIT    8
`define PPM_CS_SEL_LSB   9
`define PPM_DATA_SCALE   2'h1
`define PPM_DATA_LAST    4'h8

// ==========================================================
// Data table entries (10 mW units)
`define PPM_DATA_HI      8'h3C
`define PPM_DATA_LO      8'h2A
`define PPM_DATA_COMMON  8'h00

`endif

/* core/pmc_pkg.sv */
/*
  Types for the power management configuration registers.
  Assumes no other package.
*/
package ppm_pkg;

  // ========================================================
  // Configuration access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  idx;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ppm_cfg_req_t;

  // ========================================================
  // Device power states
  typedef enum logic [1:0] {
    PPM_D0 = 2'b00,
    PPM_D1 = 2'b01,
    PPM_D2 = 2'b10,
    PPM_D3 = 2'b11
  } ppm_pwr_state_t;

endpackage

/* core/pmc_data_rom.sv */
/*
  Hard-coded data register table and its scale.
  Assumes the select comes from a register.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"

module ppm_data_rom
  import ppm_pkg::*;
(
  input  wire logic [3:0] sel,
  output logic      [7:0] data,
  output logic      [1:0] scale
);

  // ========================================================
  // Table lookup
  always_comb
  begin
    case (sel)
      4'h0:    data = `PPM_DATA_HI;
      4'h4:    data = `PPM_DATA_HI;
      4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7:
               data = `PPM_DATA_LO;
      4'h8:    data = `PPM_DATA_COMMON;
      default: data = 8'h00;
    endcase
  end

  assign scale = (sel <= `PPM_DATA_LAST) ? `PPM_DATA_SCALE : 2'h0;

endmodule
`default_nettype wire

/* core/pmc_wake_flag.sv */
/*
  Sticky flag: hardware sets, software clears, set wins.
  Assumes set and clr are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ppm_wake_flag
  import ppm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);

  logic flag_d;

  // An event in the clearing cycle must not be lost
  assign flag_d = set | (flag_q & ~clr);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

endmodule
`default_nettype wire

/* testbench/pmc_host_model.sv */
/*
  Configuration host model: single-cycle config reads and writes.
  Assumes a strobe is taken on a rising edge and acknowledged a cycle later.
*/
`timescale 1ns/1ps
`default_nettype none

module ppm_host_model
  import ppm_pkg::*;
(
  input  wire logic        clk,
  output var ppm_cfg_req_t cfg_req,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack
);
  initial cfg_req = '0;

  // ==========================================================
  // One access, launched and finished on falling edges
  task automatic access(input logic w, input logic [5:0] i, input logic [3:0] b,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
    @(negedge clk);
    cfg_req.rd = !w;
    cfg_req.wr = w;
    cfg_req.idx = i;
    cfg_req.be = b;
    cfg_req.wdata = d;
    @(negedge clk);
    cfg_req.rd = 1'b0;
    cfg_req.wr = 1'b0;
    // Released fields invert so a stale value is never taken for a live one
    cfg_req.idx = ~i;
    cfg_req.be = ~b;
    cfg_req.wdata = ~d;
    ok = cfg_ack;
    q = cfg_rdata;
  endtask
endmodule

`default_nettype wire

/* testbench/pci_power_mgmt_config_regs_tb_top.sv */
/*
  Self-checking bench for the power management config registers.
  Assumes the host model drives the config port on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module pci_power_mgmt_config_regs_tb_top;
  import ppm_pkg::*;
  logic           clk;
  logic           rst;
  logic           aux_supply;
  logic           wake_event;
  logic           drv_pme_clr;
  ppm_cfg_req_t   cfg_req;
  logic [31:0]    cfg_rdata;
  logic           cfg_ack;
  logic           drv_pme_status;
  ppm_pwr_state_t pwr_state;
  logic           pme_n_o;
  logic           pme_n_oe;
  logic [31:0]    q;
  logic [7:0]     lfsr;
  logic [7:0]     v;
  int             fail_count = 0;
  int             compares = 0;

  ppm_config_regs i_ppm_config_regs (.clk(clk), .rst(rst), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .aux_supply(aux_supply),
    .wake_event(wake_event), .drv_pme_clr(drv_pme_clr), .drv_pme_status(drv_pme_status),
    .pwr_state(pwr_state), .pme_n_o(pme_n_o), .pme_n_oe(pme_n_oe));
  ppm_host_model i_ppm_host_model (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Expectations and helpers
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] exp_cap(input logic a);
    return {a ? 5'b11111 : 5'b01111, 2'b11, 3'b000, 1'b1, 2'b00, 3'b010, 8'h00, 8'h01};
  endfunction
  function automatic logic [31:0] exp_cs(input logic [1:0] st, input logic [3:0] s,
                                         input logic en, input logic stat);
    logic [7:0] d;
    d = (s == 4'h0 || s == 4'h4) ? 8'h3C : (s < 4'h8) ? 8'h2A : 8'h00;
    return {d, 8'h00, stat, (s <= 4'h8) ? 2'b01 : 2'b00, s, en, 6'h00, st};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [5:0] i, output logic [31:0] d);
    logic ok;
    i_ppm_host_model.access(1'b0, i, 4'h0, 32'h0, d, ok);
    chk("ack", 32'h1, {31'h0, ok});
  endtask
  task automatic wr(input logic [5:0] i, input logic [3:0] b, input logic [31:0] d);
    logic ok;
    logic [31:0] x;
    i_ppm_host_model.access(1'b1, i, b, d, x, ok);
    chk("ack", 32'h1, {31'h0, ok});
  endtask
  task automatic wake();
    @(negedge clk);
    wake_event = 1'b1;
    @(negedge clk);
    wake_event = 1'b0;
  endtask
  task automatic close_out();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Far longer than the sequence needs
  initial
  begin
    #(20 * 4000);
    fail_count++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    aux_supply = 1'b0;
    wake_event = 1'b0;
    drv_pme_clr = 1'b0;
    lfsr = 8'h08;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rd(6'h38, q);
    chk("cs_reset", exp_cs(2'b00, 4'h0, 1'b0, 1'b0), q);
    wr(6'h0D, 4'hF, 32'hFFFF_FFFF);
    rd(6'h0D, q);
    chk("cap_ptr", 32'h0000_00DC, q);
    for (int a = 0; a < 2; a++)
    begin
      aux_supply = a[0];
      wr(6'h37, 4'hF, 32'h0000_0000);
      rd(6'h37, q);
      chk("cap_word", exp_cap(a[0]), q);
    end
    rd(6'h20, q);
    chk("unmapped", 32'h0, q);
    $display("test fixed done");
    repeat (4)
    begin
      lfsr = nxt(lfsr);
      v = lfsr;
      wr(6'h0F, 4'hF, {~v, v, ~v, v});
      rd(6'h0F, q);
      chk("irq", {8'h18, 8'h08, 8'h01, v}, q);
    end
    $display("test irq done");
    for (int s = 0; s < 16; s++)
    begin
      lfsr = nxt(lfsr);
      wr(6'h38, 4'h3, {16'h0, 3'b011, s[3:0], 1'b0, 6'h3F, lfsr[1:0]});
      rd(6'h38, q);
      chk("cs_sel", exp_cs(lfsr[1:0], s[3:0], 1'b0, 1'b0), q);
      chk("state", {30'h0, lfsr[1:0]}, {30'h0, pwr_state});
    end
    $display("test select done");
    wr(6'h38, 4'h3, 32'h0);
    wake();
    chk("mirror", 32'h1, {31'h0, drv_pme_status});
    chk("oe", 32'h0, {31'h0, pme_n_oe});
    rd(6'h38, q);
    chk("cs_wake", exp_cs(2'b00, 4'h0, 1'b0, 1'b1), q);
    wr(6'h38, 4'h2, 32'h0000_0100);
    chk("oe", 32'h1, {31'h0, pme_n_oe});
    chk("pin", 32'h0, {31'h0, pme_n_o});
    @(negedge clk);
    drv_pme_clr = 1'b1;
    @(negedge clk);
    drv_pme_clr = 1'b0;
    chk("mirror", 32'h0, {31'h0, drv_pme_status});
    chk("oe", 32'h1, {31'h0, pme_n_oe});
    wr(6'h38, 4'h2, 32'h0000_8100);
    chk("oe", 32'h0, {31'h0, pme_n_oe});
    rd(6'h38, q);
    chk("cs_clr", exp_cs(2'b00, 4'h0, 1'b1, 1'b0), q);
    wake();
    wr(6'h38, 4'h1, 32'h0000_8100);
    chk("oe", 32'h1, {31'h0, pme_n_oe});
    wr(6'h38, 4'h2, 32'h0000_8100);
    chk("mirror", 32'h0, {31'h0, drv_pme_status});
    $display("test wake done");
    close_out();
  end
endmodule

`default_nettype wire
